// ### lbf_params.svh
// constants of the led blink and fade channel
`ifndef LBF_PARAMS_SVH
`define LBF_PARAMS_SVH

`define LBF_A_CTRL        12'h000
`define LBF_A_ON_TIME     12'h004
`define LBF_A_ON_LEVEL    12'h008
`define LBF_A_OFF         12'h00C
`define LBF_A_FADE_IN     12'h010
`define LBF_A_FADE_OUT    12'h014
`define LBF_A_STATUS      12'h018

`define LBF_RST_EN        1'b0
`define LBF_RST_PIN       1'b1
`define LBF_RST_LOG       1'b0
`define LBF_RST_DIV       8'h00
`define LBF_RST_ON_TIME   5'h00
`define LBF_RST_ON_LEVEL  8'hFF
`define LBF_RST_OFF       8'h00
`define LBF_RST_FADE_IN   5'h00
`define LBF_RST_FADE_OUT  5'h00

`define LBF_CTRL_EN       0
`define LBF_CTRL_PIN      1
`define LBF_CTRL_LOG      2
`define LBF_CTRL_DIV_LSB  8
`define LBF_CTRL_DIV_MSB  15
`define LBF_OFF_T_MSB     7
`define LBF_OFF_T_LSB     3
`define LBF_OFF_L_MSB     2
`define LBF_OFF_L_LSB     0
`define LBF_SET_MSB       4
`define LBF_STAT_LVL_LSB  8
`define LBF_STAT_LVL_MSB  15

`define LBF_SCALE_LO      14'd64
`define LBF_SCALE_HI      14'd512
`define LBF_RAMP_HI       14'd16
`define LBF_HI_MIN        5'd16
`define LBF_OFF_MUL       8'd4
`define LBF_UNIT_TICKS    8'd255

`endif

// ### lbf_pkg.sv
// types of the led blink and fade channel
package lbf_pkg;
  typedef enum logic [3:0] {
    lbf_st_on   = 4'b0001,
    lbf_st_fall = 4'b0010,
    lbf_st_off  = 4'b0100,
    lbf_st_rise = 4'b1000
  } lbf_state_t;

  typedef struct packed {
    logic tick;
    logic unit;
  } lbf_tick_t;

  typedef struct packed {
    logic [7:0] div;
    logic       log_mode;
    logic       pin_data;
    logic       en;
  } lbf_ctrl_t;
endpackage

// ### lbf_tick_gen.sv
// channel clock enable and 255-period unit pulse
`timescale 1ns/1ps
`default_nettype none
`include "lbf_params.svh"
module lbf_tick_gen
  import lbf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       restart,
  input  wire logic [7:0] div,
  output var lbf_tick_t   ticks
);
  logic [7:0] div_cnt_q;
  logic [7:0] unit_cnt_q;
  logic       tick_q;
  logic       unit_q;
  logic       tick_d;

  assign tick_d = (div_cnt_q == div);
  assign ticks  = '{tick: tick_q, unit: unit_q};

  // channel clock as enable every div+1 cycles
  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      div_cnt_q <= 8'h00;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= tick_d ? 8'h00 : div_cnt_q + 8'h01;
      tick_q    <= tick_d;
    end
  end

  // one unit pulse per 255 channel clock periods
  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      unit_cnt_q <= 8'h00;
      unit_q     <= 1'b0;
    end else if (tick_d) begin
      unit_q     <= (unit_cnt_q == `LBF_UNIT_TICKS - 8'h01);
      unit_cnt_q <= (unit_cnt_q == `LBF_UNIT_TICKS - 8'h01) ? 8'h00 : unit_cnt_q + 8'h01;
    end else begin
      unit_q     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### lbf_channel.sv
// led blink and fade channel with apb registers
//
// Behaviour
// - off-time field in bits 7:3; zero means off phase follows pin data
// - off-time 1..15 holds off phase 64 x value x 255 channel clocks
// - off-time 16..31 holds off phase 512 x value x 255 channel clocks
// - linear mode off intensity is four times off-level bits 2:0
// - log mode off intensity is log mapping of four times off-level field
// - fade-in field bits 4:0, upper unused; zero steps straight to on
// - fade-in 1..15 lasts (on - 4 x off) x value x 255 clocks
// - fade-in 16..31 lasts sixteen times the low-range formula
// - fade-out field bits 4:0 resets to zero; zero drops straight off
// - fade-out 1..15 lasts (on - 4 x off) x value x 255 clocks
// - fade-out 16..31 lasts sixteen times the low-range formula
// - on-time 5 bits; zero static by pin data; 64 or 512 scaling
// - linear on intensity equals 8-bit on-level; resets to 0xFF
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lbf_params.svh"
module lbf_channel
  import lbf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             led_sink_on,
  output logic      [7:0]  led_level
);
  lbf_ctrl_t  ctrl_q;
  logic [4:0] on_time_q;
  logic [7:0] on_level_q;
  logic [7:0] off_q;
  logic [4:0] fade_in_q;
  logic [4:0] fade_out_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_data;
  logic        addr_ok;
  logic        wr_en;
  lbf_state_t  st_q;
  lbf_state_t  st_d;
  logic [7:0]  lvl_q;
  logic [7:0]  lvl_d;
  logic [13:0] timer_q;
  logic [13:0] target;
  logic        hit;
  logic [7:0]  pwm_cnt_q;
  logic [7:0]  led_level_q;
  logic        led_sink_on_q;
  logic [4:0]  off_time;
  logic [7:0]  off_lvl;
  logic [7:0]  applied;
  logic        restart;
  lbf_tick_t   ticks;

  function automatic logic [13:0] phase_len(input logic [4:0] v);
    phase_len = (v < `LBF_HI_MIN) ? 14'(v) * `LBF_SCALE_LO : 14'(v) * `LBF_SCALE_HI;
  endfunction

  function automatic logic [13:0] ramp_step(input logic [4:0] v);
    ramp_step = (v < `LBF_HI_MIN) ? 14'(v) : 14'(v) * `LBF_RAMP_HI;
  endfunction

  // perceptual curve, 0 maps to 0 and 255 to 255
  function automatic logic [7:0] lbf_log(input logic [7:0] x);
    logic [15:0] p;
    p = 16'(x) * (16'(x) + 16'h0001);
    lbf_log = p[15:8];
  endfunction

  // ---------------- apb slave ----------------
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_q;

  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `LBF_A_CTRL: begin
        rd_data[`LBF_CTRL_EN]                     = ctrl_q.en;
        rd_data[`LBF_CTRL_PIN]                    = ctrl_q.pin_data;
        rd_data[`LBF_CTRL_LOG]                    = ctrl_q.log_mode;
        rd_data[`LBF_CTRL_DIV_MSB:`LBF_CTRL_DIV_LSB] = ctrl_q.div;
      end
      `LBF_A_ON_TIME:  rd_data[`LBF_SET_MSB:0] = on_time_q;
      `LBF_A_ON_LEVEL: rd_data[7:0] = on_level_q;
      `LBF_A_OFF:      rd_data[7:0] = off_q;
      `LBF_A_FADE_IN:  rd_data[`LBF_SET_MSB:0] = fade_in_q;
      `LBF_A_FADE_OUT: rd_data[`LBF_SET_MSB:0] = fade_out_q;
      `LBF_A_STATUS: begin
        rd_data[3:0]                                 = st_q;
        rd_data[`LBF_STAT_LVL_MSB:`LBF_STAT_LVL_LSB] = led_level_q;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q     <= '{div: `LBF_RST_DIV, log_mode: `LBF_RST_LOG,
                      pin_data: `LBF_RST_PIN, en: `LBF_RST_EN};
      on_time_q  <= `LBF_RST_ON_TIME;
      on_level_q <= `LBF_RST_ON_LEVEL;
      off_q      <= `LBF_RST_OFF;
      fade_in_q  <= `LBF_RST_FADE_IN;
      fade_out_q <= `LBF_RST_FADE_OUT;
    end else if (wr_en) begin
      case (paddr)
        `LBF_A_CTRL: begin
          if (pstrb[0]) begin
            ctrl_q.en       <= pwdata[`LBF_CTRL_EN];
            ctrl_q.pin_data <= pwdata[`LBF_CTRL_PIN];
            ctrl_q.log_mode <= pwdata[`LBF_CTRL_LOG];
          end
          if (pstrb[1]) begin
            ctrl_q.div <= pwdata[`LBF_CTRL_DIV_MSB:`LBF_CTRL_DIV_LSB];
          end
        end
        `LBF_A_ON_TIME:  if (pstrb[0]) on_time_q <= pwdata[`LBF_SET_MSB:0];
        `LBF_A_ON_LEVEL: if (pstrb[0]) on_level_q <= pwdata[7:0];
        `LBF_A_OFF:      if (pstrb[0]) off_q <= pwdata[7:0];
        `LBF_A_FADE_IN:  if (pstrb[0]) fade_in_q <= pwdata[`LBF_SET_MSB:0];
        `LBF_A_FADE_OUT: if (pstrb[0]) fade_out_q <= pwdata[`LBF_SET_MSB:0];
        default: ;
      endcase
    end
  end

  // ---------------- pattern engine ----------------
  // off-time field position
  assign off_time = off_q[`LBF_OFF_T_MSB:`LBF_OFF_T_LSB];
  // off intensity four times the level field
  assign off_lvl  = 8'(off_q[`LBF_OFF_L_MSB:`LBF_OFF_L_LSB]) * `LBF_OFF_MUL;
  assign restart  = (st_d != st_q) || !ctrl_q.en;

  lbf_tick_gen u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (restart),
    .div     (ctrl_q.div),
    .ticks   (ticks)
  );

  always_comb begin
    case (st_q)
      lbf_st_on:   target = phase_len(on_time_q);
      lbf_st_off:  target = phase_len(off_time);
      lbf_st_rise: target = ramp_step(fade_in_q);
      lbf_st_fall: target = ramp_step(fade_out_q);
      default:     target = phase_len(on_time_q);
    endcase
  end

  assign hit = ticks.unit && (timer_q == target - 14'h0001);

  always_comb begin
    st_d  = st_q;
    lvl_d = lvl_q;
    case (st_q)
      lbf_st_on: begin
        lvl_d = on_level_q;
        // static on phase follows pin data
        if ((on_time_q == 5'h00) ? ctrl_q.pin_data : hit) begin
          if (fade_out_q != 5'h00 && on_level_q > off_lvl) begin
            st_d = lbf_st_fall;
          end else begin
            st_d  = lbf_st_off;
            lvl_d = off_lvl;
          end
        end
      end
      lbf_st_fall: begin
        if (lvl_q <= off_lvl) begin
          st_d  = lbf_st_off;
          lvl_d = off_lvl;
        end else if (hit) begin
          // one level step per step period
          lvl_d = lvl_q - 8'h01;
          if (lvl_d == off_lvl) begin
            st_d = lbf_st_off;
          end
        end
      end
      lbf_st_off: begin
        lvl_d = off_lvl;
        // single shot off phase follows pin data
        if ((off_time == 5'h00) ? !ctrl_q.pin_data : hit) begin
          if (fade_in_q != 5'h00 && on_level_q > off_lvl) begin
            st_d = lbf_st_rise;
          end else begin
            st_d  = lbf_st_on;
            lvl_d = on_level_q;
          end
        end
      end
      lbf_st_rise: begin
        if (lvl_q >= on_level_q) begin
          st_d  = lbf_st_on;
          lvl_d = on_level_q;
        end else if (hit) begin
          // one level step per step period
          lvl_d = lvl_q + 8'h01;
          if (lvl_d == on_level_q) begin
            st_d = lbf_st_on;
          end
        end
      end
      default: begin
        st_d  = lbf_st_on;
        lvl_d = on_level_q;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q    <= lbf_st_on;
      lvl_q   <= `LBF_RST_ON_LEVEL;
      timer_q <= 14'h0000;
    end else if (!ctrl_q.en) begin
      st_q    <= lbf_st_on;
      lvl_q   <= on_level_q;
      timer_q <= 14'h0000;
    end else begin
      st_q    <= st_d;
      lvl_q   <= lvl_d;
      if (st_d != st_q || hit) begin
        timer_q <= 14'h0000;
      end else if (ticks.unit) begin
        timer_q <= timer_q + 14'h0001;
      end
    end
  end

  // ---------------- intensity and pwm ----------------
  // log or linear intensity
  assign applied = ctrl_q.log_mode ? lbf_log(lvl_q) : lvl_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_level_q <= 8'h00;
    end else begin
      led_level_q <= ctrl_q.en ? applied : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_cnt_q     <= 8'h00;
      led_sink_on_q <= 1'b0;
    end else if (ticks.tick) begin
      pwm_cnt_q     <= pwm_cnt_q + 8'h01;
      led_sink_on_q <= ctrl_q.en && (pwm_cnt_q < led_level_q);
    end else if (!ctrl_q.en) begin
      led_sink_on_q <= 1'b0;
    end
  end

  assign led_sink_on = led_sink_on_q;
  assign led_level   = led_level_q;

  // ---------------- assertions ----------------
  AST_OFF_SINGLE_SHOT: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_off && off_time == 5'h00 && ctrl_q.pin_data)
      |=> st_q == lbf_st_off)
    else $error("off phase left while single shot and pin high");

  AST_OFF_LO_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_off && st_d != lbf_st_off
     && off_time != 5'h00 && off_time < `LBF_HI_MIN)
      |-> ticks.unit && timer_q == 14'(off_time) * `LBF_SCALE_LO - 14'h0001)
    else $error("short off phase ended at wrong count");

  AST_OFF_HI_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_off && st_d != lbf_st_off && off_time >= `LBF_HI_MIN)
      |-> ticks.unit && timer_q == 14'(off_time) * `LBF_SCALE_HI - 14'h0001)
    else $error("long off phase ended at wrong count");

  AST_OFF_LIN_LVL: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && !ctrl_q.log_mode && st_q == lbf_st_off && st_d == lbf_st_off)
      ##1 (ctrl_q.en && !ctrl_q.log_mode)
      |=> led_level_q == 8'($past(off_q[`LBF_OFF_L_MSB:`LBF_OFF_L_LSB], 2)) * `LBF_OFF_MUL)
    else $error("linear off intensity wrong");

  AST_OFF_LOG_LVL: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && ctrl_q.log_mode && st_q == lbf_st_off && $stable(off_q))
      |=> led_level_q == lbf_log($past(off_lvl)))
    else $error("log off intensity wrong");

  AST_RISE_SKIP: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_off && st_d != lbf_st_off && fade_in_q == 5'h00)
      |=> st_q == lbf_st_on && lvl_q == $past(on_level_q))
    else $error("zero fade-in did not step to on");

  AST_RISE_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_rise && lvl_q < on_level_q && !hit)
      |=> lvl_q == $past(lvl_q))
    else $error("fade-in level moved between steps");

  AST_RISE_HI_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_rise && fade_in_q >= `LBF_HI_MIN && hit)
      |-> timer_q == 14'(fade_in_q) * `LBF_RAMP_HI - 14'h0001)
    else $error("long fade-in step at wrong count");

  AST_FALL_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_fall && lvl_q > off_lvl && hit)
      |=> lvl_q == $past(lvl_q) - 8'h01)
    else $error("fade-out step did not lower level by one");

  AST_FALL_HI_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_fall && fade_out_q >= `LBF_HI_MIN && hit)
      |-> timer_q == 14'(fade_out_q) * `LBF_RAMP_HI - 14'h0001)
    else $error("long fade-out step at wrong count");

  AST_CYCLE_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.en && st_q == lbf_st_on && st_d != lbf_st_on)
      |=> st_q == lbf_st_fall || st_q == lbf_st_off)
    else $error("on phase not followed by fade-out or off");
endmodule
`default_nettype wire

// ### lbf_channel_tb.sv
// self-checking testbench of the led blink and fade channel
`timescale 1ns/1ps
`default_nettype none
`include "lbf_params.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module lbf_channel_tb;
  logic        clk;
  logic        sys_rst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // pin taken as open-drain sink only, no pull-up modelled
  logic        led_sink_on;
  logic [7:0]  led_level;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t0;
  int          t1;
  int          lit;

  lbf_channel dut (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .paddr       (paddr),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .pwdata      (pwdata),
    .pstrb       (pstrb),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .led_sink_on (led_sink_on),
    .led_level   (led_level)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, whole run is about 53000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hF);
    `CHK(rd, e)
  endtask

  // poll status until the given state shows, note the cycle
  task automatic wait_state(input logic [3:0] st, output int t);
    int n;
    n = 0;
    do begin
      apb(1'b0, `LBF_A_STATUS, 32'h0, 4'hF);
      n++;
    end while (rd[3:0] !== st && n < 20000);
    t = cyc;
  endtask

  // polling step is 3 cycles, so allow 4 either way
  task automatic chk_len(input int m, input int e);
    `CHK((m >= e - 4) && (m <= e + 4), 1'b1)
  endtask

  initial begin
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;

    rd_chk(`LBF_A_CTRL, 32'h0000_0002);
    rd_chk(`LBF_A_ON_TIME, 32'h0);
    rd_chk(`LBF_A_ON_LEVEL, 32'h0000_00FF);
    rd_chk(`LBF_A_OFF, 32'h0);
    rd_chk(`LBF_A_FADE_IN, 32'h0);
    rd_chk(`LBF_A_FADE_OUT, 32'h0);
    rd_chk(`LBF_A_STATUS, 32'h0000_0001);
    `CHK(led_level, 8'h00)
    `CHK(pready, 1'b1)
    $display("test reset_values done");

    wr(`LBF_A_FADE_IN, 32'hFF);
    rd_chk(`LBF_A_FADE_IN, 32'h1F);
    wr(`LBF_A_FADE_OUT, 32'hFF);
    rd_chk(`LBF_A_FADE_OUT, 32'h1F);
    wr(`LBF_A_OFF, 32'hFF);
    rd_chk(`LBF_A_OFF, 32'hFF);
    wr(`LBF_A_ON_TIME, 32'hFF);
    rd_chk(`LBF_A_ON_TIME, 32'h1F);
    apb(1'b1, `LBF_A_ON_LEVEL, 32'h12, 4'h0);
    rd_chk(`LBF_A_ON_LEVEL, 32'hFF);
    apb(1'b0, 12'h01C, 32'h0, 4'hF);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    wr(`LBF_A_STATUS, 32'hFFFF);
    rd_chk(`LBF_A_STATUS, 32'h0000_0001);
    $display("test fields_and_refusals done");

    wr(`LBF_A_ON_TIME, 32'h0);
    wr(`LBF_A_FADE_IN, 32'h0);
    wr(`LBF_A_FADE_OUT, 32'h0);
    wr(`LBF_A_OFF, 32'h07);
    wr(`LBF_A_ON_LEVEL, 32'h80);
    wr(`LBF_A_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    rd_chk(`LBF_A_STATUS, 32'h0000_8001);
    lit = 0;
    repeat (256) begin
      @(posedge clk);
      lit += (led_sink_on === 1'b1);
    end
    `CHK(lit, 128)
    wr(`LBF_A_CTRL, 32'h3);
    repeat (10) @(posedge clk);
    rd_chk(`LBF_A_STATUS, 32'h0000_1C04);
    wr(`LBF_A_CTRL, 32'h7);
    repeat (10) @(posedge clk);
    `CHK(led_level, 8'h03)
    wr(`LBF_A_CTRL, 32'h5);
    repeat (10) @(posedge clk);
    rd_chk(`LBF_A_STATUS, 32'h0000_4001);
    wr(`LBF_A_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    `CHK(led_level, 8'h00)
    $display("test static_levels done");

    wr(`LBF_A_ON_TIME, 32'h1);
    wr(`LBF_A_ON_LEVEL, 32'h8);
    wr(`LBF_A_OFF, 32'h09);
    wr(`LBF_A_FADE_IN, 32'h2);
    wr(`LBF_A_FADE_OUT, 32'h1);
    wr(`LBF_A_CTRL, 32'h1);
    // on 64 units, fall 4 steps x 1, off 64, rise 4 steps x 2
    wait_state(4'h2, t0);
    wait_state(4'h4, t1);
    chk_len(t1 - t0, 1020);
    wait_state(4'h8, t0);
    chk_len(t0 - t1, 16320);
    wait_state(4'h1, t1);
    chk_len(t1 - t0, 2040);
    wait_state(4'h2, t0);
    chk_len(t0 - t1, 16320);
    $display("test timed_blink done");

    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(`LBF_A_CTRL, 32'h0000_0002);
    rd_chk(`LBF_A_ON_TIME, 32'h0);
    rd_chk(`LBF_A_FADE_OUT, 32'h0);
    rd_chk(`LBF_A_ON_LEVEL, 32'h0000_00FF);
    $display("test second_reset done");
    complete_run();
  end
endmodule
`default_nettype wire
